// [fcm_map.svh]
`ifndef FCM_MAP_SVH
`define FCM_MAP_SVH
// Functional notes
// [R1] Fine delay inserts up to sixteen 125 ps steps on the secondary PLL output; the code only reports it in the status register and does not draw it.
// [R2] Coarse phase moves both secondary PLL edges in 22.5 degree steps.
// [R3] Loop code goes out on the delay code bus to two slave lines.
// [R4] While code_hold is high the loop code stays frozen.
// [R5] code_update_latch captures the delay code bus for the slave lines.
// [R6] Primary and secondary loop outputs each pick one delay line tap.
// [R7] Optional fine shift adds 45, 22.5 or 11.25 degrees to the secondary tap.
// [R8] Duty cycle correction is enabled separately for each loop output.
// [R9] Secondary loop output may be divided by two or by four.
// [R10] Loop lock output is high exactly while the delay line is locked; the code registers it one cycle late.
// [R11] Each quadrant has eight primary clock lines, zero to seven.
// [R12] Identical per-quadrant center muxes let any source drive any line.
// [R13] Quadrant clock gate stops all toggling on a disabled quadrant network.
// [R14] Glitchless switch changes between two clocks without glitches or runt pulses.
// [R15] Two switches per quadrant, eight in total, drive lines six and seven.
// [R16] Switch inputs come from the center muxes, not from clock pins.
// [R17] Phase stage acts on the secondary PLL output, static or dynamic settings.
// [R18] After a dynamic adjustment PLL lock drops until the lock time passes.
// [R19] Switch parks low once old clock is low, resumes once new clock is low.
// [R20] Gate enable changes apply only while the line clock is low.

// ----------------------------------------
// register offsets
// ----------------------------------------
`define FCM_PLL_CTRL 8'h00
`define FCM_PLL_STAT 8'h04
`define FCM_DLL_CTRL 8'h08
`define FCM_DLL_STAT 8'h0C
`define FCM_QGATE 8'h10
`define FCM_QSEL0 8'h14
`define FCM_QSEL3 8'h20

// ----------------------------------------
// field positions
// ----------------------------------------
`define FCM_FINE_LSB 0
`define FCM_COARSE_LSB 8
`define FCM_FINE_DYN 16
`define FCM_COARSE_DYN 17
`define FCM_TAPP_LSB 0
`define FCM_TAPS_LSB 8
`define FCM_FSHIFT_LSB 16
`define FCM_DCCP_BIT 18
`define FCM_DCCS_BIT 19
`define FCM_DIV_LSB 20
`define FCM_TARGET_LSB 24
`define FCM_SWA_LSB 18
`define FCM_SWB_LSB 21
`define FCM_SW_STRIDE 6

// ----------------------------------------
// reset values and responses
// ----------------------------------------
`define FCM_PLL_CTRL_RST 32'h0000_0000
`define FCM_DLL_CTRL_RST 32'h4000_1000
`define FCM_QGATE_RST 4'hF
`define FCM_QSEL_RST 32'h3EFA_C688
`define FCM_RESP_OKAY 2'h0
`define FCM_RESP_SLVERR 2'h2

// ----------------------------------------
// sizes and timing
// ----------------------------------------
`define FCM_NQUAD 4
`define FCM_NLINE 8
`define FCM_NSW 8
`define FCM_FINE_MAX 5'h10
`define FCM_FINE_STEP_PS 125
`define FCM_DLL_TAPS 36
`define FCM_DCC_HALF 5'h10
`define FCM_CLK_NS 10
`define FCM_PLL_LOCK_NS 1000
`define FCM_PLL_LOCK_CYC ((`FCM_PLL_LOCK_NS + `FCM_CLK_NS - 1) / `FCM_CLK_NS)
`endif

// [fcm_pkg.sv]
package fcm_pkg;
  typedef logic [7:0] fcm_code_t;
  typedef logic [2:0] fcm_src_t;
  typedef enum logic [1:0] {FS_NONE, FS_11P25, FS_22P5, FS_45} fcm_fshift_e;
  typedef enum logic [1:0] {DIV_BY1, DIV_BY2, DIV_BY4, DIV_RSVD} fcm_div_e;
  typedef enum logic {SW_RUN, SW_PARK} fcm_sw_state_e;
endpackage

// [fcm_dll_if.sv]
interface fcm_dll_if;
  import fcm_pkg::*;
  logic hold;
  logic latch;
  fcm_code_t target;
  fcm_code_t code;
  fcm_code_t latched;
  logic lock;
  modport alu (input hold, input latch, input target, output code, output latched, output lock);
  modport ctl (output hold, output latch, output target, input code, input latched, input lock);
endinterface

// [fcm_dll_alu.sv]
module fcm_dll_alu (
  // clock and reset
  input logic ref_clk,
  input logic rst_n,
  // loop control and code
  fcm_dll_if.alu dif
);
  import fcm_pkg::*;

  fcm_code_t code_q;
  fcm_code_t latched_q;
  logic lock_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      code_q <= 8'h00;
    end else if (!dif.hold) begin // [R4]
      if (code_q < dif.target) begin
        code_q <= code_q + 8'h01;
      end else if (code_q > dif.target) begin
        code_q <= code_q - 8'h01;
      end
    end
  end

  // slave lines only see the latched copy, so tracking never jolts them mid-use
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      latched_q <= 8'h00;
    end else if (dif.latch) begin
      latched_q <= code_q; // [R5]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= 1'b0;
    end else begin
      lock_q <= (code_q == dif.target); // [R10]
    end
  end

  assign dif.code = code_q; // [R3]
  assign dif.latched = latched_q;
  assign dif.lock = lock_q;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_hold_freeze;
    dif.hold |=> $stable(dif.code);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze) else $error("code moved under hold"); // [R4]

  property p_latch_capture;
    dif.latch |=> dif.latched == $past(dif.code);
  endproperty
  a_latch_capture: assert property (p_latch_capture) else $error("latch missed bus"); // [R5]

  property p_lock_track;
    (dif.code == dif.target) |=> dif.lock;
  endproperty
  a_lock_track: assert property (p_lock_track) else $error("lock not raised"); // [R10]

  property p_track_step;
    !dif.hold && (dif.code < dif.target) |=> dif.code == $past(dif.code) + 8'h01;
  endproperty
  a_track_step: assert property (p_track_step) else $error("code did not step up"); // [R3]
endmodule

// [fcm_gclk_switch.sv]
module fcm_gclk_switch (
  // clock and reset
  input logic ref_clk,
  input logic rst_n,
  // two clocks from the center muxes
  input logic clk_a,
  input logic clk_b,
  // select from user logic
  input logic sel,
  // switched clock
  output logic clk_out
);
  import fcm_pkg::*;

  fcm_sw_state_e state_q;
  logic cur_q;
  logic tgt_q;
  logic out_q;
  logic old_clk;
  logic new_clk;

  assign old_clk = cur_q ? clk_b : clk_a;
  assign new_clk = tgt_q ? clk_b : clk_a;

  // a select flip is honoured at any time; the handover waits on both clock phases
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SW_RUN;
      cur_q <= 1'b0;
      tgt_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      case (state_q)
        SW_RUN: begin
          if ((sel != cur_q) && !old_clk) begin // [R19]
            state_q <= SW_PARK;
            tgt_q <= sel;
            out_q <= 1'b0;
          end else begin
            out_q <= old_clk; // [R14]
          end
        end
        SW_PARK: begin
          out_q <= 1'b0;
          if (!new_clk) begin // [R19]
            cur_q <= tgt_q;
            state_q <= SW_RUN;
          end
        end
        default: begin
          state_q <= SW_RUN;
          out_q <= 1'b0;
        end
      endcase
    end
  end

  assign clk_out = out_q;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_park_entry;
    (state_q == SW_RUN) && (sel != cur_q) && !old_clk;
  endsequence
  sequence s_parked_low;
    (state_q == SW_PARK) && !clk_out;
  endsequence

  property p_park_low;
    s_park_entry |=> s_parked_low;
  endproperty
  a_park_low: assert property (p_park_low) else $error("switch did not park low"); // [R19]

  property p_follow;
    (state_q == SW_RUN) && (sel == cur_q) |=> clk_out == $past(old_clk);
  endproperty
  a_follow: assert property (p_follow) else $error("output left selected clock"); // [R14]

  property p_resume;
    (state_q == SW_PARK) && !new_clk |=> (state_q == SW_RUN) && !clk_out;
  endproperty
  a_resume: assert property (p_resume) else $error("resume not on low clock"); // [R19]
endmodule

// [fcm_top.sv]
// Our own choices: the address map and the AXI4-Lite slave port.
`include "fcm_map.svh"

module fcm_top (
  // clock and reset
  input logic ref_clk,
  input logic rst_n,
  // axi4-lite write address
  input logic [7:0] s_axi_awaddr,
  input logic [2:0] s_axi_awprot,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  // axi4-lite read address
  input logic [7:0] s_axi_araddr,
  input logic [2:0] s_axi_arprot,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  // pll dynamic phase controls
  input logic [4:0] pll_fine_dyn,
  input logic [3:0] pll_coarse_dyn,
  // pll outputs
  output logic pll_primary_out,
  output logic pll_secondary_out,
  output logic pll_lock,
  // delay-locked loop
  input logic dll_ref_clk,
  input logic code_hold,
  input logic code_update_latch,
  output fcm_pkg::fcm_code_t delay_code_bus,
  output fcm_pkg::fcm_code_t slave_delay_code,
  output logic primary_clock_out,
  output logic secondary_clock_out,
  output logic dll_lock,
  // primary clock network
  input logic [7:0] clk_src,
  input logic [7:0] switch_sel,
  output logic [31:0] quad_clk
);
  import fcm_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic fcm_pick(input logic [7:0] src, input fcm_src_t idx);
    return src[idx];
  endfunction

  function automatic logic fcm_is_qsel(input logic [7:0] addr);
    return (addr >= `FCM_QSEL0) && (addr <= `FCM_QSEL3) && (addr[1:0] == 2'h0);
  endfunction

  function automatic logic [1:0] fcm_qidx(input logic [7:0] addr);
    logic [7:0] off;
    off = addr - `FCM_QSEL0;
    return off[3:2];
  endfunction

  function automatic logic fcm_hit(input logic [7:0] addr);
    case (addr)
      `FCM_PLL_CTRL, `FCM_PLL_STAT, `FCM_DLL_CTRL, `FCM_DLL_STAT, `FCM_QGATE: return 1'b1;
      default: return fcm_is_qsel(addr);
    endcase
  endfunction

  function automatic logic [31:0] fcm_merge(input logic [31:0] old, input logic [31:0] dat,
                                           input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [4:0] fcm_dcc(input logic [4:0] cnt, input logic rise);
    if (rise) begin
      return `FCM_DCC_HALF - 5'h01;
    end
    return (cnt != 5'h00) ? cnt - 5'h01 : 5'h00;
  endfunction

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q, rd_val;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic [31:0] pll_ctrl_q, dll_ctrl_q;
  logic [3:0] qgate_q;
  logic [31:0] qsel_q [`FCM_NQUAD];

  // address and data may arrive in either order; the write lands once both are held
  assign wr_fire = !awready_q && !wready_q && !bvalid_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `FCM_RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        awaddr_q <= s_axi_awaddr;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        wready_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= fcm_hit(awaddr_q) ? `FCM_RESP_OKAY : `FCM_RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // status registers ignore writes but still answer okay
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_ctrl_q <= `FCM_PLL_CTRL_RST;
      dll_ctrl_q <= `FCM_DLL_CTRL_RST;
      qgate_q <= `FCM_QGATE_RST;
      for (int q = 0; q < `FCM_NQUAD; q++) begin
        qsel_q[q] <= `FCM_QSEL_RST;
      end
    end else if (wr_fire) begin
      if (fcm_is_qsel(awaddr_q)) begin
        qsel_q[fcm_qidx(awaddr_q)] <= fcm_merge(qsel_q[fcm_qidx(awaddr_q)], wdata_q, wstrb_q);
      end
      case (awaddr_q)
        `FCM_PLL_CTRL: pll_ctrl_q <= fcm_merge(pll_ctrl_q, wdata_q, wstrb_q);
        `FCM_DLL_CTRL: dll_ctrl_q <= fcm_merge(dll_ctrl_q, wdata_q, wstrb_q);
        `FCM_QGATE: begin
          if (wstrb_q[0]) begin
            qgate_q <= wdata_q[3:0];
          end
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // pll phase stage
  // ----------------------------------------
  logic [4:0] fine_sel, fine_eff, fine_prev_q;
  logic [3:0] coarse_eff, coarse_prev_q, pll_ph_q, sec_ph;
  logic [11:0] fine_ps_q;
  logic [7:0] lock_cnt_q;
  logic pll_primary_q, pll_secondary_q, pll_lock_q, phase_chg;

  assign fine_sel = pll_ctrl_q[`FCM_FINE_DYN] ? pll_fine_dyn : pll_ctrl_q[`FCM_FINE_LSB +: 5];
  assign fine_eff = (fine_sel > `FCM_FINE_MAX) ? `FCM_FINE_MAX : fine_sel; // [R1]
  assign coarse_eff = pll_ctrl_q[`FCM_COARSE_DYN] ? pll_coarse_dyn
                                                  : pll_ctrl_q[`FCM_COARSE_LSB +: 4]; // [R17]
  assign sec_ph = pll_ph_q - coarse_eff;
  assign phase_chg = (fine_eff != fine_prev_q) || (coarse_eff != coarse_prev_q);

  // sixteen coarse steps span one period; sub-cycle fine delay is reported, not drawn
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_ph_q <= 4'h0;
      pll_primary_q <= 1'b0;
      pll_secondary_q <= 1'b0;
      fine_ps_q <= 12'h000;
    end else begin
      pll_ph_q <= pll_ph_q + 4'h1;
      pll_primary_q <= ~pll_ph_q[3];
      pll_secondary_q <= ~sec_ph[3]; // [R2]
      fine_ps_q <= 12'(fine_eff) * 12'(`FCM_FINE_STEP_PS); // [R1]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fine_prev_q <= 5'h00;
      coarse_prev_q <= 4'h0;
      lock_cnt_q <= 8'(`FCM_PLL_LOCK_CYC);
      pll_lock_q <= 1'b0;
    end else begin
      fine_prev_q <= fine_eff;
      coarse_prev_q <= coarse_eff;
      if (phase_chg) begin
        lock_cnt_q <= 8'(`FCM_PLL_LOCK_CYC); // [R18]
      end else if (lock_cnt_q != 8'h00) begin
        lock_cnt_q <= lock_cnt_q - 8'h01;
      end
      pll_lock_q <= (lock_cnt_q == 8'h00) && !phase_chg; // [R18]
    end
  end

  // ----------------------------------------
  // delay-locked loop
  // ----------------------------------------
  fcm_dll_if u_dif ();
  logic [`FCM_DLL_TAPS-1:0] tap_q;
  logic [5:0] tap_s_idx;
  logic [2:0] shamt;
  logic p_raw, s_raw, p_raw_q, s_raw_q, p_pre, s_pre, s_pre_q;
  logic [4:0] dcc_p_q, dcc_s_q;
  logic [1:0] div_q;
  logic prim_q, sec_q;
  fcm_div_e div_mode;

  assign u_dif.hold = code_hold;
  assign u_dif.latch = code_update_latch;
  assign u_dif.target = dll_ctrl_q[`FCM_TARGET_LSB +: 8];

  fcm_dll_alu u_alu (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .dif(u_dif.alu)
  );

  always_comb begin
    case (fcm_fshift_e'(dll_ctrl_q[`FCM_FSHIFT_LSB +: 2]))
      FS_11P25: shamt = 3'h1; // [R7]
      FS_22P5: shamt = 3'h2;
      FS_45: shamt = 3'h4;
      default: shamt = 3'h0;
    endcase
  end

  assign div_mode = fcm_div_e'(dll_ctrl_q[`FCM_DIV_LSB +: 2]);
  assign tap_s_idx = {1'b0, dll_ctrl_q[`FCM_TAPS_LSB +: 5]} + {3'h0, shamt};
  assign p_raw = tap_q[dll_ctrl_q[`FCM_TAPP_LSB +: 5]]; // [R6]
  assign s_raw = tap_q[tap_s_idx]; // [R6]
  assign p_pre = dll_ctrl_q[`FCM_DCCP_BIT] ? ((p_raw && !p_raw_q) || dcc_p_q != 5'h00) : p_raw;
  assign s_pre = dll_ctrl_q[`FCM_DCCS_BIT] ? ((s_raw && !s_raw_q) || dcc_s_q != 5'h00) : s_raw;

  // one tap per cycle: a 32-cycle reference gives 11.25 degrees per tap
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tap_q <= '0;
      p_raw_q <= 1'b0;
      s_raw_q <= 1'b0;
      dcc_p_q <= 5'h00;
      dcc_s_q <= 5'h00;
    end else begin
      tap_q <= {tap_q[`FCM_DLL_TAPS-2:0], dll_ref_clk};
      p_raw_q <= p_raw;
      s_raw_q <= s_raw;
      dcc_p_q <= fcm_dcc(dcc_p_q, p_raw && !p_raw_q); // [R8]
      dcc_s_q <= fcm_dcc(dcc_s_q, s_raw && !s_raw_q); // [R8]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_pre_q <= 1'b0;
      div_q <= 2'h0;
      prim_q <= 1'b0;
      sec_q <= 1'b0;
    end else begin
      s_pre_q <= s_pre;
      if (s_pre && !s_pre_q) begin
        div_q <= div_q + 2'h1;
      end
      prim_q <= p_pre;
      case (div_mode)
        DIV_BY2: sec_q <= div_q[0]; // [R9]
        DIV_BY4: sec_q <= div_q[1]; // [R9]
        default: sec_q <= s_pre;
      endcase
    end
  end

  // ----------------------------------------
  // primary clock network
  // ----------------------------------------
  logic [`FCM_NSW-1:0] sw_out;
  logic [31:0] line_val, line_en_q, quad_clk_q;

  for (genvar q = 0; q < `FCM_NQUAD; q++) begin : g_quad
    for (genvar s = 0; s < 2; s++) begin : g_sw
      fcm_gclk_switch u_sw (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_a(fcm_pick(clk_src, qsel_q[q][`FCM_SWA_LSB + `FCM_SW_STRIDE*s +: 3])), // [R16]
        .clk_b(fcm_pick(clk_src, qsel_q[q][`FCM_SWB_LSB + `FCM_SW_STRIDE*s +: 3])), // [R16]
        .sel(switch_sel[2*q+s]),
        .clk_out(sw_out[2*q+s]) // [R15]
      );
    end
  end

  always_comb begin
    line_val = 32'h0000_0000;
    for (int q = 0; q < `FCM_NQUAD; q++) begin
      for (int l = 0; l < 6; l++) begin
        line_val[`FCM_NLINE*q+l] = fcm_pick(clk_src, qsel_q[q][3*l +: 3]); // [R12]
      end
      line_val[`FCM_NLINE*q+6] = sw_out[2*q]; // [R15]
      line_val[`FCM_NLINE*q+7] = sw_out[2*q+1]; // [R11]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_en_q <= 32'hFFFF_FFFF;
      quad_clk_q <= 32'h0000_0000;
    end else begin
      for (int i = 0; i < 32; i++) begin
        if (!line_val[i]) begin
          line_en_q[i] <= qgate_q[i/`FCM_NLINE]; // [R20]
        end
      end
      quad_clk_q <= line_en_q & line_val; // [R13]
    end
  end

  // ----------------------------------------
  // reads and outputs
  // ----------------------------------------
  always_comb begin
    rd_val = 32'h0000_0000;
    if (fcm_is_qsel(s_axi_araddr)) begin
      rd_val = qsel_q[fcm_qidx(s_axi_araddr)];
    end else begin
      case (s_axi_araddr)
        `FCM_PLL_CTRL: rd_val = pll_ctrl_q;
        `FCM_PLL_STAT: rd_val = {fine_ps_q, coarse_eff, 3'h0, fine_eff, 7'h00, pll_lock_q};
        `FCM_DLL_CTRL: rd_val = dll_ctrl_q;
        `FCM_DLL_STAT: rd_val = {8'h00, u_dif.latched, u_dif.code, 7'h00, u_dif.lock};
        `FCM_QGATE: rd_val = {28'h000_0000, qgate_q};
        default: rd_val = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `FCM_RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= fcm_hit(s_axi_araddr) ? `FCM_RESP_OKAY : `FCM_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign pll_primary_out = pll_primary_q;
  assign pll_secondary_out = pll_secondary_q;
  assign pll_lock = pll_lock_q;
  assign delay_code_bus = u_dif.code; // [R3]
  assign slave_delay_code = u_dif.latched; // [R5]
  assign dll_lock = u_dif.lock;
  assign primary_clock_out = prim_q;
  assign secondary_clock_out = sec_q;
  assign quad_clk = quad_clk_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_phase_move;
    phase_chg;
  endsequence
  property p_lock_drop;
    s_phase_move |=> !pll_lock_q [*8];
  endproperty
  a_lock_drop: assert property (p_lock_drop) else $error("pll lock kept after move"); // [R18]

  property p_coarse_zero;
    (coarse_eff == 4'h0) && $stable(coarse_eff) |=> pll_secondary_q == pll_primary_q;
  endproperty
  a_coarse_zero: assert property (p_coarse_zero) else $error("secondary off phase"); // [R2]

  property p_gate_low;
    $changed(line_en_q[0]) |-> !$past(line_val[0]);
  endproperty
  a_gate_low: assert property (p_gate_low) else $error("gate changed on high clock"); // [R20]

  property p_gate_off;
    !line_en_q[0] |=> !quad_clk_q[0];
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("gated line toggled"); // [R13]

  property p_dcc_width;
    dll_ctrl_q[`FCM_DCCP_BIT] && $stable(dll_ctrl_q) && p_raw && !p_raw_q |=> prim_q [*8];
  endproperty
  a_dcc_width: assert property (p_dcc_width) else $error("duty correction pulse short"); // [R8]
endmodule

// [fcm_fabric_model.sv]
module fcm_fabric_model (
  // clock and reset
  input logic ref_clk,
  input logic rst_n,
  // free-running sources for the center muxes and the loop reference
  output logic [7:0] clk_src,
  output logic dll_ref_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // sources are level-sampled by ref_clk, so none runs faster than clk/4
  assign clk_src = {~cnt_q[4:1], cnt_q[4:1]};
  assign dll_ref_clk = cnt_q[4];
endmodule

// [testbench.sv]
`include "fcm_map.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import fcm_pkg::*;
  logic ref_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic code_hold, code_update_latch, pll_primary_out, pll_secondary_out, pll_lock;
  logic dll_ref_clk, primary_clock_out, secondary_clock_out, dll_lock;
  logic [7:0] s_axi_awaddr, s_axi_araddr, clk_src, switch_sel, acc0, acc1, hp;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [3:0] s_axi_wstrb, pll_coarse_dyn;
  logic [4:0] pll_fine_dyn;
  logic [31:0] s_axi_wdata, s_axi_rdata, quad_clk, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  fcm_code_t delay_code_bus, slave_delay_code;
  int failures, tests_run;
  fcm_top u_fcm_top (.*);
  fcm_fabric_model u_fcm_fabric_model (.*);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic tally_and_finish;
    if (failures == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    rdr(`FCM_DLL_CTRL);
    chk("dll_ctrl", `FCM_DLL_CTRL_RST, rd);
    rdr(`FCM_QGATE);
    chk("qgate", {28'h0, `FCM_QGATE_RST}, rd);
    for (int q = 0; q < 4; q++) begin
      rdr(`FCM_QSEL0 + 8'(4 * q));
      chk("qsel", `FCM_QSEL_RST, rd);
    end
    rdr(8'h40);
    chk("bad_rd", {30'h0, `FCM_RESP_SLVERR}, {30'h0, rs});
    wr(8'h40, 32'hFFFF_FFFF);
    chk("bad_wr", {30'h0, `FCM_RESP_SLVERR}, {30'h0, rs});
  endtask
  task automatic t_pll;
    wr(`FCM_PLL_CTRL, 32'h0000_030A);
    rdr(`FCM_PLL_STAT);
    chk("pll_stat", {12'h4E2, 4'h3, 3'h0, 5'hA, 8'h00}, rd);
    repeat (110) @(posedge ref_clk);
    chk("pll_lock", 32'h1, {31'h0, pll_lock});
    pll_fine_dyn <= 5'h14;
    pll_coarse_dyn <= 4'h5;
    wr(`FCM_PLL_CTRL, 32'h0003_0000);
    rdr(`FCM_PLL_STAT);
    chk("pll_dyn", {12'h7D0, 4'h5, 3'h0, 5'h10, 8'h00}, rd);
    for (int i = 0; i < 24; i++) begin
      @(posedge ref_clk);
      hp = {hp[6:0], pll_primary_out};
      if (i > 5) chk("pll_sec", {31'h0, hp[5]}, {31'h0, pll_secondary_out});
    end
  endtask
  task automatic t_dll;
    for (int n = 0; n < 200 && dll_lock !== 1'b1; n++) @(posedge ref_clk);
    chk("code", 32'h40, {24'h0, delay_code_bus});
    code_hold <= 1'b1;
    wr(`FCM_DLL_CTRL, 32'h5004_1000);
    repeat (20) @(posedge ref_clk);
    chk("hold", 32'h40, {24'h0, delay_code_bus});
    chk("unlock", 32'h0, {31'h0, dll_lock});
    chk("slave0", 32'h0, {24'h0, slave_delay_code});
    code_hold <= 1'b0;
    repeat (20) @(posedge ref_clk);
    code_update_latch <= 1'b1;
    @(posedge ref_clk);
    code_update_latch <= 1'b0;
    rdr(`FCM_DLL_STAT);
    chk("dll_stat", 32'h0050_5001, rd);
    repeat (8) begin
      @(posedge ref_clk);
      chk("dll_out", {31'h0, ~primary_clock_out}, {31'h0, secondary_clock_out});
    end
    wr(`FCM_DLL_CTRL, 32'h5024_1000);
    @(posedge ref_clk);
    hp = {7'h0, secondary_clock_out};
    acc0 = 8'h00;
    repeat (128) begin
      @(posedge ref_clk);
      acc0 = acc0 + {7'h0, secondary_clock_out && !hp[0]};
      hp = {7'h0, secondary_clock_out};
    end
    chk("div4", 32'h1, {24'h0, acc0});
  endtask
  task automatic t_gate;
    switch_sel <= 8'hFF;
    wr(`FCM_QGATE, 32'h0000_000E);
    repeat (20) @(posedge ref_clk);
    acc0 = 8'h00;
    acc1 = 8'h00;
    repeat (40) begin
      @(posedge ref_clk);
      acc0 = acc0 | quad_clk[7:0];
      acc1 = acc1 | quad_clk[15:8];
    end
    chk("gated", 32'h0, {24'h0, acc0});
    chk("live", 32'h1, {31'h0, acc1[0]});
  endtask
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {code_hold, code_update_latch, s_axi_awaddr, s_axi_araddr, switch_sel} = '0;
    {s_axi_awprot, s_axi_arprot, pll_coarse_dyn, pll_fine_dyn, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    failures = 0;
    tests_run = 0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs();
    t_pll();
    t_dll();
    t_gate();
    tally_and_finish();
  end
  // cut a hang short well beyond the few hundred cycles the scenarios need
  initial begin
    #200000;
    failures++;
    tally_and_finish();
  end
endmodule
